// ---- rcsel_cfg.svh ----
// constants for the clock source select and start-up block
//--------------------------------------------------------------
// Notes on behaviour
// - external RC: source codes 0101..1000 pick four frequency ranges, 0.1 to 12 MHz
// - external RC start-up: 00=18 CK, 01=18 CK+4.1ms, 10=18 CK+65ms, 11=6 CK+4.1ms
// - internal RC: source codes 0001..0100 give 1, 2, 4, 8 MHz nominal
// - delivered fuses: internal RC 1 MHz with start-up code 10
// - internal RC start-up: 6 CK; 00 none, 01 4.1ms, 10 65ms; 11 reserved
// - every reset loads the 1 MHz factory trim byte into the trim register
// - reset trim comes from signature row location 0x00, high byte
// - 8-bit trim register is read/write; 00 slowest, FF fastest
// - trim span: 00 50-100%, 7F 75-150%, FF 100-200% of nominal
// - with internal RC, reset time-out still runs on the watchdog oscillator
// - external clock on the oscillator input pin only with source code 0000
// - external clock start-up: 6 CK; 00 none, 01 4.1ms, 10 65ms; 11 reserved
// - reset delays count watchdog cycles: 4.1ms is 4096, 65ms is 65536
//--------------------------------------------------------------
`ifndef RCSEL_CFG_SVH
`define RCSEL_CFG_SVH

// register map
`define RCSEL_ADR_TRIM 8'h00
`define RCSEL_ADR_STATUS 8'h04

// source select codes
`define RCSEL_CK_EXT_CLK 4'h0
`define RCSEL_CK_INT_LO 4'h1
`define RCSEL_CK_INT_HI 4'h4
`define RCSEL_CK_ERC_LO 4'h5
`define RCSEL_CK_ERC_HI 4'h8

// start-up codes
`define RCSEL_SUT_NONE 2'h0
`define RCSEL_SUT_SHORT 2'h1
`define RCSEL_SUT_LONG 2'h2
`define RCSEL_SUT_ALT 2'h3

// start-up cycle counts of the selected clock
`define RCSEL_START_LONG_CK 5'h12
`define RCSEL_START_SHORT_CK 5'h06

// edges ignored for the first 5 cycles after reset, past the false rise of a pin already high at release
`define RCSEL_SYNC_PRIME 3'h5

// reset delays, time in us and watchdog cycles
`define RCSEL_DLY_SHORT_US 4100
`define RCSEL_DLY_LONG_US 65000
`define RCSEL_WDT_SHORT_CYC 4096
`define RCSEL_WDT_LONG_CYC 65536

// trim load
`define RCSEL_SIG_TRIM_ADR 8'h00
`define RCSEL_TRIM_RST 8'h00

`endif

// ---- rcsel_pkg.sv ----
// types for the clock source select and start-up block
`default_nettype none
package rcsel_pkg;

  typedef enum logic [4:0] {
    ST_SAMPLE = 5'b00001,
    ST_START = 5'b00010,
    ST_DELAY = 5'b00100,
    ST_RUN = 5'b01000,
    ST_HALT = 5'b10000
  } rcsel_state_t;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_EXT_RC = 2'h1,
    SRC_INT_RC = 2'h2,
    SRC_EXT_CLK = 2'h3
  } rcsel_src_t;

  typedef enum logic [1:0] {
    DLY_NONE = 2'h0,
    DLY_SHORT = 2'h1,
    DLY_LONG = 2'h2,
    DLY_BAD = 2'h3
  } rcsel_dly_t;

  typedef struct packed {
    logic [3:0] ck_src;
    logic [1:0] startup_time_fuses;
    logic opt_unprog;
  } rcsel_fuse_t;

endpackage
`default_nettype wire

// ---- rcsel_edge_sync.sv ----
// three-stage synchroniser with rising edge pulse
`default_nettype none
module rcsel_edge_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic rise_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_reg <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
      end
      rise_o <= (s2_reg == s3_reg) && s3_reg && !level_reg;
    end
  end

endmodule
`default_nettype wire

// ---- rcsel_top.sv ----
// clock source select, start-up sequencer and oscillator trim register
//
// The Wishbone register port and the address map were decided locally.
`include "rcsel_cfg.svh"
`default_nettype none
module rcsel_top
  import rcsel_pkg::*;
#(
  parameter int unsigned DLY_SHORT_CYC = `RCSEL_WDT_SHORT_CYC,
  parameter int unsigned DLY_LONG_CYC = `RCSEL_WDT_LONG_CYC
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire rcsel_fuse_t FUSE_I,
  input wire logic OSC_INPUT_PIN_I,
  input wire logic INT_RC_CLK_I,
  input wire logic WDT_OSC_I,
  input wire logic [15:0] SIG_DATA_I,
  output logic SIG_RD_O,
  output logic [7:0] SIG_ADDR_O,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic ERR_O,
  output rcsel_src_t CLK_SRC_O,
  output logic [1:0] RANGE_O,
  output logic CLK_RELEASE_O,
  output logic RESET_HOLD_O,
  output logic CAP_EN_O,
  output logic [7:0] TRIM_O
);

  //--------------------------------------------------------------
  // delay counts
  //--------------------------------------------------------------
  localparam logic [16:0] DLY_SHORT_N = 17'(DLY_SHORT_CYC - 1);
  localparam logic [16:0] DLY_LONG_N = 17'(DLY_LONG_CYC - 1);

  //--------------------------------------------------------------
  // decoding
  //--------------------------------------------------------------
  function automatic rcsel_src_t src_of(input logic [3:0] code);
    rcsel_src_t s;
    s = SRC_NONE;
    if (code == `RCSEL_CK_EXT_CLK) begin
      s = SRC_EXT_CLK;
    end else if (code >= `RCSEL_CK_INT_LO && code <= `RCSEL_CK_INT_HI) begin
      s = SRC_INT_RC;
    end else if (code >= `RCSEL_CK_ERC_LO && code <= `RCSEL_CK_ERC_HI) begin
      s = SRC_EXT_RC;
    end
    return s;
  endfunction

  function automatic logic [1:0] range_of(input logic [3:0] code);
    logic [1:0] r;
    r = 2'h0;
    case (src_of(code))
      SRC_INT_RC: begin
        r = 2'(code - `RCSEL_CK_INT_LO);
      end
      SRC_EXT_RC: begin
        r = 2'(code - `RCSEL_CK_ERC_LO);
      end
      default: begin
        r = 2'h0;
      end
    endcase
    return r;
  endfunction

  function automatic logic [4:0] start_of(input rcsel_src_t s, input logic [1:0] startup_time_fuses);
    logic [4:0] n;
    n = `RCSEL_START_SHORT_CK;
    if (s == SRC_EXT_RC && startup_time_fuses != `RCSEL_SUT_ALT) begin
      n = `RCSEL_START_LONG_CK;
    end
    return n;
  endfunction

  function automatic rcsel_dly_t dly_of(input rcsel_src_t s, input logic [1:0] startup_time_fuses);
    rcsel_dly_t d;
    case (startup_time_fuses)
      `RCSEL_SUT_NONE: begin
        d = DLY_NONE;
      end
      `RCSEL_SUT_SHORT: begin
        d = DLY_SHORT;
      end
      `RCSEL_SUT_LONG: begin
        d = DLY_LONG;
      end
      default: begin
        d = (s == SRC_EXT_RC) ? DLY_SHORT : DLY_BAD;
      end
    endcase
    if (s == SRC_NONE) begin
      d = DLY_BAD;
    end
    return d;
  endfunction

  //--------------------------------------------------------------
  // pin synchronisers
  //--------------------------------------------------------------
  logic [2:0] pin_async;
  logic [2:0] pin_rise;

  assign pin_async = {WDT_OSC_I, INT_RC_CLK_I, OSC_INPUT_PIN_I};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      rcsel_edge_sync u_sync (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .async_i(pin_async[gi]),
        .rise_o(pin_rise[gi])
      );
    end
  endgenerate

  logic osc_pin_rise;
  logic int_rc_rise;
  logic wdt_rise;

  // the stages restart at zero, so a pin already high at release would look like
  // an edge and shorten the start-up count; edges are ignored until that has passed
  logic [2:0] prime_cnt_reg;
  logic primed;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      prime_cnt_reg <= 3'h0;
    end else if (prime_cnt_reg != `RCSEL_SYNC_PRIME) begin
      prime_cnt_reg <= 3'(prime_cnt_reg + 3'h1);
    end
  end

  assign primed = (prime_cnt_reg == `RCSEL_SYNC_PRIME);
  assign osc_pin_rise = primed && pin_rise[0];
  assign int_rc_rise = primed && pin_rise[1];
  assign wdt_rise = primed && pin_rise[2];

  //--------------------------------------------------------------
  // fuse sampling
  //--------------------------------------------------------------
  rcsel_state_t state_reg;
  rcsel_state_t state_next;
  rcsel_fuse_t fuse_reg;
  rcsel_src_t src_reg;
  rcsel_dly_t dly_reg;
  logic [4:0] start_n_reg;
  logic opt_conflict_reg;

  // codes are caught once after reset and then frozen
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      fuse_reg <= '{ck_src: `RCSEL_CK_INT_LO, startup_time_fuses: `RCSEL_SUT_LONG, opt_unprog: 1'b1};
      src_reg <= SRC_NONE;
      dly_reg <= DLY_BAD;
      start_n_reg <= 5'h00;
      opt_conflict_reg <= 1'b0;
    end else if (state_reg == ST_SAMPLE) begin
      fuse_reg <= FUSE_I;
      src_reg <= src_of(FUSE_I.ck_src);
      dly_reg <= dly_of(src_of(FUSE_I.ck_src), FUSE_I.startup_time_fuses);
      start_n_reg <= start_of(src_of(FUSE_I.ck_src), FUSE_I.startup_time_fuses);
      // flagged only; the clock still runs
      opt_conflict_reg <= (src_of(FUSE_I.ck_src) == SRC_INT_RC) && !FUSE_I.opt_unprog;
    end
  end

  //--------------------------------------------------------------
  // start-up sequencer
  //--------------------------------------------------------------
  logic [4:0] start_cnt_reg;
  logic [16:0] dly_cnt_reg;
  logic src_edge;
  logic start_done;
  logic dly_done;

  // start-up cycles are edges of the chosen source
  assign src_edge = (src_reg == SRC_INT_RC) ? int_rc_rise : osc_pin_rise;
  assign start_done = src_edge && (start_cnt_reg == 5'(start_n_reg - 5'h01));
  assign dly_done = wdt_rise &&
    (dly_cnt_reg == ((dly_reg == DLY_LONG) ? DLY_LONG_N : DLY_SHORT_N));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SAMPLE: begin
        if (dly_of(src_of(FUSE_I.ck_src), FUSE_I.startup_time_fuses) == DLY_BAD) begin
          state_next = ST_HALT;
        end else begin
          state_next = ST_START;
        end
      end
      ST_START: begin
        if (start_done) begin
          state_next = (dly_reg == DLY_NONE) ? ST_RUN : ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (dly_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        state_next = ST_RUN;
      end
      ST_HALT: begin
        state_next = ST_HALT;
      end
      default: begin
        state_next = ST_HALT;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_reg <= ST_SAMPLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      start_cnt_reg <= 5'h00;
    end else if (state_reg != ST_START) begin
      start_cnt_reg <= 5'h00;
    end else if (src_edge) begin
      start_cnt_reg <= 5'(start_cnt_reg + 5'h01);
    end
  end

  // reset delay runs on the watchdog oscillator whatever the source
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      dly_cnt_reg <= 17'h00000;
    end else if (state_reg != ST_DELAY) begin
      dly_cnt_reg <= 17'h00000;
    end else if (wdt_rise) begin
      dly_cnt_reg <= 17'(dly_cnt_reg + 17'h00001);
    end
  end

  //--------------------------------------------------------------
  // clock outputs
  //--------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      CLK_SRC_O <= SRC_NONE;
      RANGE_O <= 2'h0;
      CLK_RELEASE_O <= 1'b0;
      RESET_HOLD_O <= 1'b1;
      CAP_EN_O <= 1'b0;
    end else begin
      CLK_SRC_O <= src_reg;
      RANGE_O <= range_of(fuse_reg.ck_src);
      // held in reset until released; reserved codes hold forever
      CLK_RELEASE_O <= (state_next == ST_RUN);
      RESET_HOLD_O <= (state_next != ST_RUN);
      // internal load capacitor only for the pin-driven sources
      CAP_EN_O <= !fuse_reg.opt_unprog &&
        (src_reg == SRC_EXT_RC || src_reg == SRC_EXT_CLK);
    end
  end

  //--------------------------------------------------------------
  // factory trim fetch
  //--------------------------------------------------------------
  // the row is read while the fuses are sampled, same clock
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      SIG_RD_O <= 1'b1;
      SIG_ADDR_O <= `RCSEL_SIG_TRIM_ADR;
    end else begin
      SIG_RD_O <= 1'b0;
      SIG_ADDR_O <= `RCSEL_SIG_TRIM_ADR;
    end
  end

  //--------------------------------------------------------------
  // wishbone slave
  //--------------------------------------------------------------
  logic req;
  logic mapped;
  logic [31:0] status_word;

  assign req = CYC_I && STB_I;
  assign mapped = (ADR_I == `RCSEL_ADR_TRIM) || (ADR_I == `RCSEL_ADR_STATUS);

  assign status_word = {15'h0000, opt_conflict_reg, RANGE_O, fuse_reg.opt_unprog,
    fuse_reg.startup_time_fuses, fuse_reg.ck_src, src_reg, state_reg};

  // one wait state; ack drops the cycle after it was given
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ACK_O <= 1'b0;
      ERR_O <= 1'b0;
    end else begin
      ACK_O <= req && mapped && !ACK_O && !ERR_O;
      ERR_O <= req && !mapped && !ACK_O && !ERR_O;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      DAT_O <= 32'h00000000;
    end else if (req && !ACK_O && !ERR_O) begin
      case (ADR_I)
        `RCSEL_ADR_TRIM: begin
          DAT_O <= {24'h000000, TRIM_O};
        end
        `RCSEL_ADR_STATUS: begin
          DAT_O <= status_word;
        end
        default: begin
          DAT_O <= 32'h00000000;
        end
      endcase
    end
  end

  //--------------------------------------------------------------
  // trim register
  //--------------------------------------------------------------
  // any trim is accepted; memory-write safety is up to software
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      TRIM_O <= `RCSEL_TRIM_RST;
    end else if (state_reg == ST_SAMPLE) begin
      TRIM_O <= SIG_DATA_I[15:8];
    end else if (ACK_O && req && WE_I && SEL_I[0] && ADR_I == `RCSEL_ADR_TRIM) begin
      TRIM_O <= DAT_I[7:0];
    end
  end

endmodule
`default_nettype wire

// ---- rcsel_osc_model.sv ----
// free-running oscillator model for one clock input of the block
`default_nettype none
module rcsel_osc_model #(
  parameter int HALF = 5
) (
  input wire logic clk_i,
  input wire logic en_i,
  output logic osc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial osc_o = 1'b0;
  // fixed period: never jumps between cycles, and stands still when disabled
  always @(posedge clk_i) begin
    if (!en_i) begin
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      osc_o <= ~osc_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ---- rcsel_top_chk.sv ----
// assertions on the ports of the clock select block
`default_nettype none
module rcsel_top_chk
  import rcsel_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire rcsel_fuse_t FUSE_I,
  input wire logic [15:0] SIG_DATA_I,
  input wire logic SIG_RD_O,
  input wire logic [7:0] SIG_ADDR_O,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic ERR_O,
  input wire rcsel_src_t CLK_SRC_O,
  input wire logic CLK_RELEASE_O,
  input wire logic RESET_HOLD_O,
  input wire logic [7:0] TRIM_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  logic req;
  logic reserved_reg;
  assign req = CYC_I && STB_I && !ACK_O && !ERR_O;
  // reserved codes caught at the first edge after reset, where the block samples them
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      reserved_reg <= 1'b0;
    end else if ($past(SYS_RST_I)) begin
      reserved_reg <= FUSE_I.ck_src > 4'h8 || (FUSE_I.ck_src < 4'h5 && FUSE_I.startup_time_fuses == 2'h3);
    end
  end
  function automatic rcsel_src_t src_of(logic [3:0] c);
    return c > 4'h8 ? SRC_NONE : c == 4'h0 ? SRC_EXT_CLK : c < 4'h5 ? SRC_INT_RC : SRC_EXT_RC;
  endfunction
  sequence s_taken;
    req;
  endsequence
  sequence s_answer;
    (ACK_O ^ ERR_O) ##1 !(ACK_O || ERR_O);
  endsequence
  chk_bus_answer: assert property (s_taken |=> s_answer)
    else $error("bus answer wrong");
  chk_unmapped_err: assert property (req && ADR_I != 8'h00 && ADR_I != 8'h04 |=> ERR_O && !ACK_O)
    else $error("unmapped access not refused");
  chk_trim_write: assert property (
    ACK_O && WE_I && ADR_I == 8'h00 && SEL_I[0] |=> TRIM_O == $past(DAT_I[7:0]))
    else $error("trim write lost");
  chk_trim_read: assert property (ACK_O && !WE_I && ADR_I == 8'h00 |-> DAT_O == {24'h000000, TRIM_O})
    else $error("trim read wrong");
  chk_trim_load: assert property (
    $fell(SYS_RST_I) |-> SIG_RD_O && SIG_ADDR_O == 8'h00 ##1 TRIM_O == $past(SIG_DATA_I[15:8]))
    else $error("factory trim not loaded");
  chk_src_decode: assert property (
    $fell(SYS_RST_I) |-> ##2 CLK_SRC_O == src_of($past(FUSE_I.ck_src, 2)))
    else $error("source decode wrong");
  chk_no_early: assert property ($fell(SYS_RST_I) |-> !CLK_RELEASE_O [*8])
    else $error("clock released too early");
  // release is sticky so that a glitching source cannot drop the clock again
  chk_release_hold: assert property (CLK_RELEASE_O |=> CLK_RELEASE_O && !RESET_HOLD_O)
    else $error("release dropped");
  chk_no_release: assert property (
    CLK_SRC_O == SRC_NONE || reserved_reg |-> !CLK_RELEASE_O && RESET_HOLD_O)
    else $error("reserved code released clock");
endmodule
`default_nettype wire

// ---- test_rcsel_top.sv ----
// self-checking bench for the clock select block
`default_nettype none
module test_rcsel_top
  import rcsel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, osc_en = 1'b0, int_en = 1'b0, wdt_en = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, wb_q;
  logic [15:0] sig = 16'h0;
  rcsel_fuse_t fuse = 7'h00;
  rcsel_src_t src;
  logic [1:0] rng;
  logic ack, err, rel, hold, cap, osc, intc, wdt;
  logic [7:0] trim;
  int n_errors = 0, num_checks = 0;
  // ck, sut, src, range, start edges (0 = halt), delay code
  logic [27:0] tbl [14] = '{28'h1220062, 28'h0030060, 28'h0130061, 28'h0230062, 28'h0330000, 28'h2021060,
    28'h3122061, 28'h4023060, 28'h2321000, 28'h5010120, 28'h6111121, 28'h7212122, 28'h8313061, 28'h9000000};
  always #20 clk = ~clk;
  rcsel_osc_model #(.HALF(5)) u_rcsel_osc_model (.clk_i(clk), .en_i(osc_en), .osc_o(osc));
  rcsel_osc_model #(.HALF(4)) u_rcsel_osc_model_rc (.clk_i(clk), .en_i(int_en), .osc_o(intc));
  // separate free-running watchdog oscillator times every reset delay
  rcsel_osc_model #(.HALF(6)) u_rcsel_osc_model_wdt (.clk_i(clk), .en_i(wdt_en), .osc_o(wdt));
  rcsel_top #(.DLY_SHORT_CYC(8), .DLY_LONG_CYC(16)) u_rcsel_top (.CLK_I(clk), .SYS_RST_I(rst), .FUSE_I(fuse),
    .OSC_INPUT_PIN_I(osc), .INT_RC_CLK_I(intc), .WDT_OSC_I(wdt), .SIG_DATA_I(sig), .SIG_RD_O(), .SIG_ADDR_O(),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(rdat), .ACK_O(ack),
    .ERR_O(err), .CLK_SRC_O(src), .RANGE_O(rng), .CLK_RELEASE_O(rel), .RESET_HOLD_O(hold), .CAP_EN_O(cap),
    .TRIM_O(trim));
  task automatic results();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d, input logic e);
    int k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (!(ack === 1'b1 || err === 1'b1) && k < 20);
    wb_q = rdat;
    chk({30'h0, ack, err}, e ? 32'h1 : 32'h2);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic boot(input logic [6:0] f, input logic [15:0] s);
    @(posedge clk);
    rst <= 1'b1;
    fuse <= f;
    sig <= s;
    wdt_en <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask
  initial begin
    #800000;
    n_errors++;
    results();
  end
  initial begin
    logic [27:0] e;
    logic opt;
    logic [31:0] m, st;
    logic [7:0] v;
    int d, p, n, t, lo, hi;
    for (int i = 0; i < 14; i++) begin
      e = tbl[i];
      n = e[11:4];
      opt = (e[19:16] == 4'h2 || n == 0) ? 1'b1 : i[0];
      d = e[3:0] == 4'h1 ? 8 : e[3:0] == 4'h2 ? 16 : 0;
      p = e[19:16] == 4'h2 ? 8 : 10;
      osc_en <= e[19:16] != 4'h2;
      int_en <= e[19:16] == 4'h2 || n == 0;
      boot({e[27:24], e[21:20], opt}, {8'hA5 ^ 8'(i), 8'h3C});
      t = 0;
      while (rel !== 1'b1 && t < 600) begin
        @(posedge clk);
        t++;
      end
      lo = n ? (n - 1) * p + (d ? (d - 1) * 12 : 0) : 600;
      hi = n ? n * p + d * 12 + p + 22 : 600;
      chk({31'h0, t >= lo && t <= hi}, 32'h1);
      m = n ? 32'hFFFFFFFF : 32'hFFFF3FFF;
      st = {16'h0000, e[13:12], opt, e[21:20], e[27:24], e[17:16], n ? 5'h08 : 5'h10};
      chk({18'h0, src, rng & m[15:14], cap, hold, trim},
        {18'h0, e[17:16], e[13:12] & m[15:14], !opt && e[16], n == 0, 8'hA5 ^ 8'(i)});
      for (int j = 0; j < 2; j++) begin
        wb(1'b0, 8'h04, 4'h1, 32'h0, 1'b0);
        chk(wb_q & m, st & m);
        fuse <= 7'h7F;
      end
      if (i == 0) begin
        for (int j = 0; j < 3; j++) begin
          // no memory write runs here, so the full trim span is safe
          v = j == 0 ? 8'hFF : j == 1 ? 8'h00 : 8'h7F;
          wb(1'b1, 8'h00, 4'h1, {24'h0, v}, 1'b0);
          wb(1'b0, 8'h00, 4'h1, 32'h0, 1'b0);
          chk(wb_q, {24'h0, v});
          chk({24'h0, trim}, {24'h0, v});
        end
        wb(1'b1, 8'h00, 4'h0, 32'h11, 1'b0);
        wb(1'b1, 8'h04, 4'h1, 32'h0, 1'b0);
        wb(1'b0, 8'h00, 4'h1, 32'h0, 1'b0);
        chk(wb_q, 32'h7F);
        wb(1'b0, 8'h08, 4'h1, 32'h0, 1'b1);
        wb(1'b1, 8'hFC, 4'h1, 32'h5A, 1'b1);
      end
    end
    results();
  end
endmodule
bind rcsel_top rcsel_top_chk u_rcsel_top_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .FUSE_I(FUSE_I),
  .SIG_DATA_I(SIG_DATA_I), .SIG_RD_O(SIG_RD_O), .SIG_ADDR_O(SIG_ADDR_O), .CYC_I(CYC_I), .STB_I(STB_I),
  .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .ERR_O(ERR_O),
  .CLK_SRC_O(CLK_SRC_O), .CLK_RELEASE_O(CLK_RELEASE_O), .RESET_HOLD_O(RESET_HOLD_O), .TRIM_O(TRIM_O));
`default_nettype wire
